/* File: core/extender_regs.svh */
// Timing and counter-width constants for the two-wire extender holdoff controllers.
`ifndef EXTENDER_REGS_SVH
`define EXTENDER_REGS_SVH
`define CLK_PERIOD_PS      32'd8000
`define DRIVE_TIME_PS      32'd1750000
`define HOLDOFF_TIME_PS    32'd2500000
`define DRIVE_CYCLES       ((`DRIVE_TIME_PS) / (`CLK_PERIOD_PS))
`define HOLDOFF_CYCLES     ((`HOLDOFF_TIME_PS) / (`CLK_PERIOD_PS))
`define CNT_WIDTH          9
`endif

/* File: core/extender_pkg.sv */
// Types shared by the two-wire extender controllers.
`default_nettype none
package extender_pkg;
  typedef enum logic [2:0] {
    ST_IDLE_HIGH = 3'b000,
    ST_FALL_HOLD = 3'b001,
    ST_LOW_SENSE = 3'b010,
    ST_RISE_HOLD = 3'b011,
    ST_HIGH_WAIT = 3'b100
  } hold_state_t;
endpackage
`default_nettype wire

/* File: core/line_holdoff_fsm.sv */
// One per-line holdoff state machine for the cable extender.
`timescale 1ns/100ps
`default_nettype none
`include "extender_regs.svh"
module line_holdoff_fsm #(
  parameter bit          IS_DATA       = 1'b0,
  parameter int unsigned CNT_W         = `CNT_WIDTH,
  parameter int unsigned DRIVE_CYCLES  = `DRIVE_CYCLES,
  parameter int unsigned HOLD_CYCLES   = `HOLDOFF_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic driver_enable_in,
  input  wire logic series_mode,
  input  wire logic cable_below_fall,
  input  wire logic disp_below_fall,
  input  wire logic cable_above_release,
  input  wire logic disp_above_release,
  input  wire logic cable_above_high,
  input  wire logic disp_above_high,
  input  wire logic cable_below_exit,
  input  wire logic disp_below_exit,
  output logic      cable_pulldown,
  output logic      cable_pullup,
  output logic      disp_pulldown,
  output logic      cable_clamp,
  output logic      disp_clamp,
  output logic      cable_term_en,
  output logic      sense_en,
  output extender_pkg::hold_state_t state
);
  extender_pkg::hold_state_t state_r;
  extender_pkg::hold_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic             hold_done;
  logic             drive_phase;
  logic             series_r;

  assign hold_done   = (cnt_r == CNT_W'(HOLD_CYCLES - 1));
  assign drive_phase = (cnt_r < CNT_W'(DRIVE_CYCLES));
  assign state       = state_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      extender_pkg::ST_IDLE_HIGH:
        if (cable_below_fall || disp_below_fall)
          state_nxt = extender_pkg::ST_FALL_HOLD;
      extender_pkg::ST_FALL_HOLD:
        if (hold_done)
          state_nxt = extender_pkg::ST_LOW_SENSE;
      extender_pkg::ST_LOW_SENSE:
        if (cable_above_release && disp_above_release)
          state_nxt = extender_pkg::ST_RISE_HOLD;
      extender_pkg::ST_RISE_HOLD:
        if (hold_done)
          state_nxt = extender_pkg::ST_HIGH_WAIT;
      extender_pkg::ST_HIGH_WAIT:
        if ((cable_above_high && disp_above_high) || (IS_DATA && (cable_below_exit || disp_below_exit)))
          state_nxt = extender_pkg::ST_IDLE_HIGH;
      default:
        state_nxt = extender_pkg::ST_IDLE_HIGH;
    endcase
  end

  // Disabled controllers idle high so re-enable starts from a clean state.
  always_ff @(posedge mclk)
  begin
    if (rst || !driver_enable_in)
      state_r <= extender_pkg::ST_IDLE_HIGH;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || state_nxt != state_r)
      cnt_r <= '0;
    else if (!hold_done)
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // Mode is registered per cycle; a change mid-hold takes effect one cycle later.
  always_ff @(posedge mclk)
  begin
    if (rst)
      series_r <= 1'b0;
    else
      series_r <= series_mode;
  end

  logic fall_hold;
  logic rise_hold;
  assign fall_hold = (state_r == extender_pkg::ST_FALL_HOLD);
  assign rise_hold = (state_r == extender_pkg::ST_RISE_HOLD);

  always_comb
  begin
    cable_pulldown = driver_enable_in && fall_hold && drive_phase;
    disp_pulldown  = cable_pulldown;
    cable_pullup   = driver_enable_in && rise_hold && drive_phase;
    cable_term_en  = driver_enable_in && (fall_hold || rise_hold) && drive_phase;
    cable_clamp    = driver_enable_in && series_r &&
                     ((fall_hold && !drive_phase) ||
                      (state_r == extender_pkg::ST_LOW_SENSE && cable_above_release && !disp_above_release));
    disp_clamp     = driver_enable_in && series_r &&
                     ((fall_hold && !drive_phase) ||
                      (state_r == extender_pkg::ST_LOW_SENSE && disp_above_release && !cable_above_release));
    sense_en       = (state_r == extender_pkg::ST_IDLE_HIGH) || (state_r == extender_pkg::ST_LOW_SENSE) ||
                     (state_r == extender_pkg::ST_HIGH_WAIT);
  end

  hold_len_a: assert property (@(posedge mclk) disable iff (rst || !driver_enable_in)
    $rose(state_r == extender_pkg::ST_FALL_HOLD) |-> (state_r == extender_pkg::ST_FALL_HOLD)[*8])
    else $error("fall holdoff ended too early");
endmodule // line_holdoff_fsm
`default_nettype wire

/* File: core/twowire_extender_holdoff_ctrl.sv */
// Top of the two-wire extender: clock and data holdoff controllers.
`timescale 1ns/100ps
`default_nettype none
`include "extender_regs.svh"
module twowire_extender_holdoff_ctrl #(
  parameter int unsigned DRIVE_CYCLES = `DRIVE_CYCLES,
  parameter int unsigned HOLD_CYCLES  = `HOLDOFF_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       driver_enable_in,
  input  wire logic       mode_parallel,
  input  wire logic [1:0] cable_below_fall,
  input  wire logic [1:0] disp_below_fall,
  input  wire logic [1:0] cable_above_release,
  input  wire logic [1:0] disp_above_release,
  input  wire logic [1:0] cable_above_high,
  input  wire logic [1:0] disp_above_high,
  input  wire logic [1:0] cable_below_exit,
  input  wire logic [1:0] disp_below_exit,
  output logic      [1:0] cable_pulldown,
  output logic      [1:0] cable_pullup,
  output logic      [1:0] disp_pulldown,
  output logic      [1:0] cable_clamp,
  output logic      [1:0] disp_clamp,
  output logic      [1:0] cable_term_en,
  output logic      [1:0] sense_en
);
  // Index 0 is the clock line, index 1 the data line.
  extender_pkg::hold_state_t st [2];
  logic series_mode;
  assign series_mode = !mode_parallel;

  for (genvar i = 0; i < 2; i++)
  begin : g_line
    line_holdoff_fsm #(
      .IS_DATA      (i == 1),
      .DRIVE_CYCLES (DRIVE_CYCLES),
      .HOLD_CYCLES  (HOLD_CYCLES)
    ) u_fsm (
      .mclk                (mclk),
      .rst                 (rst),
      .driver_enable_in    (driver_enable_in),
      .series_mode         (series_mode),
      .cable_below_fall    (cable_below_fall[i]),
      .disp_below_fall     (disp_below_fall[i]),
      .cable_above_release (cable_above_release[i]),
      .disp_above_release  (disp_above_release[i]),
      .cable_above_high    (cable_above_high[i]),
      .disp_above_high     (disp_above_high[i]),
      .cable_below_exit    (cable_below_exit[i]),
      .disp_below_exit     (disp_below_exit[i]),
      .cable_pulldown      (cable_pulldown[i]),
      .cable_pullup        (cable_pullup[i]),
      .disp_pulldown       (disp_pulldown[i]),
      .cable_clamp         (cable_clamp[i]),
      .disp_clamp          (disp_clamp[i]),
      .cable_term_en       (cable_term_en[i]),
      .sense_en            (sense_en[i]),
      .state               (st[i])
    );
  end

  fall_start_a: assert property (@(posedge mclk) disable iff (rst)
    (driver_enable_in && st[0] == extender_pkg::ST_IDLE_HIGH && cable_below_fall[0])
      |=> (cable_pulldown[0] && disp_pulldown[0] || !driver_enable_in) && !sense_en[0])
    else $error("falling decision did not drive low");
  drive_off_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(cable_pulldown[1]) && driver_enable_in |-> st[1] == extender_pkg::ST_FALL_HOLD)
    else $error("pulldown released outside holdoff");
  hold_blank_a: assert property (@(posedge mclk) disable iff (rst)
    (st[0] == extender_pkg::ST_FALL_HOLD || st[0] == extender_pkg::ST_RISE_HOLD) |-> !sense_en[0])
    else $error("sensing active during holdoff");
  low_sense_a: assert property (@(posedge mclk) disable iff (rst)
    st[1] == extender_pkg::ST_LOW_SENSE |-> sense_en[1] && !cable_pulldown[1] && !cable_pullup[1])
    else $error("low sense state drives");
  wired_and_a: assert property (@(posedge mclk) disable iff (rst)
    (st[0] == extender_pkg::ST_LOW_SENSE && !(cable_above_release[0] && disp_above_release[0]))
      |=> st[0] != extender_pkg::ST_RISE_HOLD)
    else $error("rose while one side low");
  rise_term_a: assert property (@(posedge mclk) disable iff (rst)
    cable_pullup[1] |-> cable_term_en[1] && !disp_pulldown[1])
    else $error("pullup without termination");
  clamp_mode_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_parallel && $past(mode_parallel)) |-> cable_clamp == 2'b00)
    else $error("clamp in parallel mode");
  isolate_a: assert property (@(posedge mclk) disable iff (rst)
    !driver_enable_in |-> (cable_pulldown | cable_pullup | disp_pulldown | cable_clamp | disp_clamp) == 2'b00)
    else $error("drivers on while disabled");
  clk_exit_a: assert property (@(posedge mclk) disable iff (rst)
    (driver_enable_in && st[0] == extender_pkg::ST_HIGH_WAIT && !(cable_above_high[0] && disp_above_high[0]))
      |=> st[0] == extender_pkg::ST_HIGH_WAIT)
    else $error("clock left high wait early");

  data_exit_a: assert property (@(posedge mclk) disable iff (rst)
    (driver_enable_in && st[1] == extender_pkg::ST_HIGH_WAIT && (cable_below_exit[1] || disp_below_exit[1]))
      |=> st[1] == extender_pkg::ST_IDLE_HIGH)
    else $error("data did not leave high wait on low level");

  // Interval checkers count the driver and blanking windows from the pins themselves.
  // A fault in the controller's own counter therefore cannot hide behind the same arithmetic.
  for (genvar i = 0; i < 2; i++)
  begin : g_chk
    logic [15:0] drive_len_r;
    logic [15:0] blank_len_r;
    logic        series_seen;

    assign series_seen = !mode_parallel && driver_enable_in;

    always_ff @(posedge mclk)
    begin
      if (rst || !(cable_pulldown[i] || cable_pullup[i]))
        drive_len_r <= 16'h0000;
      else
        drive_len_r <= drive_len_r + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
      if (rst || sense_en[i])
        blank_len_r <= 16'h0000;
      else
        blank_len_r <= blank_len_r + 16'h0001;
    end

    pd_len_a: assert property (@(posedge mclk) disable iff (rst)
      ($fell(cable_pulldown[i]) && driver_enable_in)
        |-> drive_len_r == DRIVE_CYCLES)
      else $error("pulldown window has the wrong length");

    pu_len_a: assert property (@(posedge mclk) disable iff (rst)
      ($fell(cable_pullup[i]) && driver_enable_in)
        |-> drive_len_r == DRIVE_CYCLES)
      else $error("pullup window has the wrong length");

    blank_len_a: assert property (@(posedge mclk) disable iff (rst)
      ($rose(sense_en[i]) && driver_enable_in && $past(driver_enable_in) && !$past(rst))
        |-> blank_len_r == HOLD_CYCLES)
      else $error("holdoff has the wrong length");

    term_win_a: assert property (@(posedge mclk) disable iff (rst)
      cable_term_en[i]
        |-> cable_pulldown[i] || cable_pullup[i])
      else $error("termination outside the drive window");

    idle_quiet_a: assert property (@(posedge mclk) disable iff (rst)
      st[i] == extender_pkg::ST_IDLE_HIGH
        |-> sense_en[i] && !(cable_pulldown[i] || cable_pullup[i] || disp_pulldown[i] || cable_term_en[i]))
      else $error("idle line drives or does not sense");

    high_hold_a: assert property (@(posedge mclk) disable iff (rst)
      st[i] == extender_pkg::ST_RISE_HOLD
        |-> !sense_en[i] && !disp_pulldown[i] && !cable_clamp[i] && !disp_clamp[i])
      else $error("high holdoff drives low or senses");

    rise_take_a: assert property (@(posedge mclk) disable iff (rst)
      (driver_enable_in && st[i] == extender_pkg::ST_LOW_SENSE && cable_above_release[i] && disp_above_release[i])
        |=> st[i] == extender_pkg::ST_RISE_HOLD)
      else $error("release of both sides not taken");

    high_exit_a: assert property (@(posedge mclk) disable iff (rst)
      (driver_enable_in && st[i] == extender_pkg::ST_HIGH_WAIT && cable_above_high[i] && disp_above_high[i])
        |=> st[i] == extender_pkg::ST_IDLE_HIGH)
      else $error("high wait not left with both levels high");

    fall_take_a: assert property (@(posedge mclk) disable iff (rst)
      (driver_enable_in && st[i] == extender_pkg::ST_IDLE_HIGH && disp_below_fall[i])
        |=> st[i] == extender_pkg::ST_FALL_HOLD)
      else $error("display side fall not taken");

    cable_side_a: assert property (@(posedge mclk) disable iff (rst)
      (series_seen && $past(series_seen) && st[i] == extender_pkg::ST_LOW_SENSE &&
       cable_above_release[i] && !disp_above_release[i])
        |-> cable_clamp[i] && !disp_clamp[i])
      else $error("released cable side not clamped");

    disp_side_a: assert property (@(posedge mclk) disable iff (rst)
      (series_seen && $past(series_seen) && st[i] == extender_pkg::ST_LOW_SENSE &&
       disp_above_release[i] && !cable_above_release[i])
        |-> disp_clamp[i] && !cable_clamp[i])
      else $error("released display side not clamped");

    low_clamp_a: assert property (@(posedge mclk) disable iff (rst)
      (series_seen && $past(series_seen) && st[i] == extender_pkg::ST_FALL_HOLD && !cable_pulldown[i])
        |-> cable_clamp[i] && disp_clamp[i])
      else $error("low holdoff not clamped in series mode");

    par_clamp_a: assert property (@(posedge mclk) disable iff (rst)
      (mode_parallel && $past(mode_parallel))
        |-> !disp_clamp[i])
      else $error("display clamp in parallel mode");

    fall_block_a: assert property (@(posedge mclk) disable iff (rst)
      (driver_enable_in && st[i] == extender_pkg::ST_FALL_HOLD && !sense_en[i] && blank_len_r < 16'h0002)
        |=> st[i] == extender_pkg::ST_FALL_HOLD || !driver_enable_in)
      else $error("fall holdoff left at once");

    en_idle_a: assert property (@(posedge mclk) disable iff (rst)
      !driver_enable_in
        |=> st[i] == extender_pkg::ST_IDLE_HIGH)
      else $error("disabled line not forced idle");
  end
endmodule // twowire_extender_holdoff_ctrl
`default_nettype wire

/* File: dv/line_side_model.sv */
// Far-side model: cable source and display devices on the clock and data lines.
`timescale 1ns/100ps
`default_nettype none
module line_side_model (
  input  wire logic [1:0] src_pull,
  input  wire logic [1:0] disp_pull,
  input  wire logic [1:0] slow_rise,
  input  wire logic [1:0] cable_pulldown,
  input  wire logic [1:0] disp_pulldown,
  output logic      [1:0] cable_below_fall,
  output logic      [1:0] disp_below_fall,
  output logic      [1:0] cable_above_release,
  output logic      [1:0] disp_above_release,
  output logic      [1:0] cable_above_high,
  output logic      [1:0] disp_above_high,
  output logic      [1:0] cable_below_exit,
  output logic      [1:0] disp_below_exit
);
  logic [1:0] c_low;
  logic [1:0] d_low;
  // Each node is a wired-AND: low while any client or the device pulls it.
  assign c_low = src_pull | cable_pulldown;
  assign d_low = disp_pull | disp_pulldown;
  assign cable_below_fall = c_low;
  assign disp_below_fall = d_low;
  assign cable_above_release = ~c_low;
  assign disp_above_release = ~d_low;
  // A heavily loaded line may stall both its cable and display nodes between the release and high levels.
  assign cable_above_high = ~c_low & ~slow_rise;
  assign disp_above_high = ~d_low & ~slow_rise;
  assign cable_below_exit = c_low;
  assign disp_below_exit = d_low;
endmodule // line_side_model
`default_nettype wire

/* File: dv/twowire_extender_holdoff_ctrl_tb.sv */
// Self-checking bench for the two-wire extender holdoff controllers.
`timescale 1ns/100ps
`default_nettype none
module twowire_extender_holdoff_ctrl_tb;
  localparam int DRV = 10;
  localparam int HLD = 16;
  typedef struct packed {logic [1:0] ln; logic par; logic src; logic dsp; logic [1:0] clamp;} row_t;
  row_t       rows [8] = '{'{2'b01, 1'b1, 1'b1, 1'b0, 2'b00}, '{2'b01, 1'b1, 1'b0, 1'b1, 2'b00},
                           '{2'b01, 1'b0, 1'b1, 1'b0, 2'b01}, '{2'b01, 1'b0, 1'b0, 1'b1, 2'b01},
                           '{2'b10, 1'b1, 1'b1, 1'b1, 2'b00}, '{2'b10, 1'b0, 1'b1, 1'b1, 2'b10},
                           '{2'b10, 1'b1, 1'b0, 1'b1, 2'b00}, '{2'b10, 1'b0, 1'b1, 1'b0, 2'b10}};
  row_t       r;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       en = 1'b1;
  logic       par = 1'b1;
  logic [1:0] sp = 2'b00, dp = 2'b00, slow = 2'b00;
  logic [1:0] cbf, dbf, car, dar, cah, dah, cbe, dbe;
  logic [1:0] cpd, cpu, dpd, ccl, dcl, cte, sen;
  int         errors = 0;
  int         samples_checked = 0;
  always #4 mclk = ~mclk;
  twowire_extender_holdoff_ctrl #(.DRIVE_CYCLES(DRV), .HOLD_CYCLES(HLD)) dut (
    .mclk(mclk), .rst(rst), .driver_enable_in(en), .mode_parallel(par),
    .cable_below_fall(cbf), .disp_below_fall(dbf), .cable_above_release(car), .disp_above_release(dar),
    .cable_above_high(cah), .disp_above_high(dah), .cable_below_exit(cbe), .disp_below_exit(dbe),
    .cable_pulldown(cpd), .cable_pullup(cpu), .disp_pulldown(dpd), .cable_clamp(ccl), .disp_clamp(dcl),
    .cable_term_en(cte), .sense_en(sen));
  line_side_model far (
    .src_pull(sp), .disp_pull(dp), .slow_rise(slow), .cable_pulldown(cpd), .disp_pulldown(dpd),
    .cable_below_fall(cbf), .disp_below_fall(dbf), .cable_above_release(car), .disp_above_release(dar),
    .cable_above_high(cah), .disp_above_high(dah), .cable_below_exit(cbe), .disp_below_exit(dbe));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Pull requests change only at a clock edge, in bursts with idle gaps between them.
  task automatic drv(input logic [1:0] s, input logic [1:0] d);
    @(posedge mclk);
    sp <= s;
    dp <= d;
  endtask
  task automatic check(input string nm, input logic [1:0] seen, input logic [1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    check("rst_sense", sen, 2'b11);
    check("rst_drv", cpd | dpd | cpu | cte | ccl | dcl, 2'b00);
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      @(posedge mclk);
      par <= r.par;
      tick(2);
      drv(r.src ? r.ln : 2'b00, r.dsp ? r.ln : 2'b00);
      tick(1);
      check("fall_pd", cpd & dpd & r.ln, r.ln);
      check("fall_term", cte & r.ln, r.ln);
      check("fall_sense", sen, ~r.ln);
      tick(DRV - 1);
      check("pd_last", cpd & dpd & cte & r.ln, r.ln);
      tick(1);
      check("pd_off", (cpd | dpd | cte) & r.ln, 2'b00);
      check("low_clamp", (ccl | dcl) & r.ln, r.clamp);
      tick(HLD - DRV);
      check("low_sense", sen & r.ln, r.ln);
      drv(2'b00, 2'b00);
      tick(1);
      check("rise_pu", cpu & cte & r.ln, r.ln);
      check("rise_sense", (sen | dpd) & r.ln, 2'b00);
      tick(DRV - 1);
      check("pu_last", cpu & cte & r.ln, r.ln);
      tick(1);
      check("pu_off", (cpu | cte) & r.ln, 2'b00);
      tick(HLD - DRV + 1);
      check("idle", sen, 2'b11);
      $display("row %0d done", i);
    end
    drv(2'b01, 2'b01);
    tick(HLD + 1);
    drv(2'b00, 2'b01);
    tick(3);
    check("one_up", cpu, 2'b00);
    check("one_clamp", ccl, 2'b01);
    drv(2'b00, 2'b00);
    tick(1);
    check("both_up", cpu, 2'b01);
    tick(HLD + 1);
    $display("series release done");
    drv(2'b11, 2'b00);
    slow <= 2'b11;
    tick(HLD + 1);
    drv(2'b00, 2'b00);
    tick(HLD + 3);
    check("wait_high", sen, 2'b11);
    drv(2'b11, 2'b00);
    tick(3);
    check("exit_low", cpd, 2'b10);
    drv(2'b00, 2'b00);
    slow <= 2'b00;
    tick(2 * HLD + 4);
    check("settled", sen, 2'b11);
    $display("high wait done");
    drv(2'b11, 2'b11);
    tick(2);
    @(posedge mclk);
    en <= 1'b0;
    tick(1);
    check("off_drv", cpd | dpd | cpu | ccl | dcl, 2'b00);
    drv(2'b00, 2'b00);
    en <= 1'b1;
    tick(3);
    check("back_idle", sen, 2'b11);
    $display("enable done");
    drv(2'b11, 2'b11);
    tick(3);
    @(posedge mclk);
    rst <= 1'b1;
    tick(2);
    check("mid_rst_drv", cpd | dpd | cpu | cte | ccl | dcl, 2'b00);
    check("mid_rst_sense", sen, 2'b11);
    drv(2'b00, 2'b00);
    @(posedge mclk);
    rst <= 1'b0;
    tick(2);
    check("post_rst", sen, 2'b11);
    $display("mid reset done");
    end_sim;
  end
endmodule // twowire_extender_holdoff_ctrl_tb
`default_nettype wire
